// ==== design/arm_pkg.sv ====
package arm_pkg;
    localparam int CODE_W     = 8;
    localparam int HIST_DEPTH = 10;
    localparam int IDX_W      = 4;
    localparam int NPIN       = 8;
    localparam int PSEL_W     = 3;
    localparam int CFG_W      = 8;
    localparam int HOUR_W     = 12;
    // clock rate in Hz and the duplicate window in seconds
    localparam int CLK_HZ     = 50_000_000;
    localparam int HOUR_S     = 3600;
    // cycles per one-second tick, derived from the clock rate
    localparam int SEC_CYCLES = CLK_HZ * 1;
    localparam logic [HOUR_W-1:0] HOUR_SEC = HOUR_W'(HOUR_S);

    typedef logic [CODE_W-1:0] arm_code_t;
    typedef logic [IDX_W-1:0]  arm_idx_t;
endpackage : arm_pkg

// ==== design/arm_hist_if.sv ====
interface arm_hist_if;
    import arm_pkg::*;
    logic      wr;
    arm_code_t wr_code;
    logic      clr;
    logic      rd_en;
    arm_idx_t  rd_idx;
    arm_code_t rd_code;
    logic      rd_valid;

    modport ctl (output wr, wr_code, clr, rd_en, rd_idx,
                 input  rd_code, rd_valid);
    modport mem (input  wr, wr_code, clr, rd_en, rd_idx,
                 output rd_code, rd_valid);
endinterface : arm_hist_if

// ==== design/arm_hist_mem.sv ====
module arm_hist_mem
    import arm_pkg::*;
(
    input  wire logic core_clk,  // system clock
    input  wire logic ce,        // clock enable
    arm_hist_if.mem   hist       // history port
);
    arm_code_t code_q   [HIST_DEPTH];
    arm_code_t code_nxt [HIST_DEPTH];
    logic [HIST_DEPTH-1:0] vld_q;
    logic [HIST_DEPTH-1:0] vld_nxt;
    arm_code_t rd_code_r;
    arm_code_t rd_code_nxt;
    logic      rd_valid_r;
    logic      rd_valid_nxt;

    // contents stand for nonvolatile storage: no reset touches them
    always_comb begin
        code_nxt     = code_q;
        vld_nxt      = vld_q;
        rd_code_nxt  = rd_code_r;
        rd_valid_nxt = rd_valid_r;
        if (hist.clr) begin
            vld_nxt = '0;
        end
        // shift newest in
        // a write beside a clear survives as the only entry
        if (hist.wr) begin
            for (int i = HIST_DEPTH - 1; i > 0; i--) begin
                code_nxt[i] = code_q[i-1];
            end
            code_nxt[0] = hist.wr_code;
            vld_nxt     = {vld_nxt[HIST_DEPTH-2:0], 1'b1};
        end
        if (hist.rd_en) begin
            if (int'(hist.rd_idx) < HIST_DEPTH) begin
                rd_code_nxt  = code_q[hist.rd_idx];
                rd_valid_nxt = vld_q[hist.rd_idx];
            end else begin
                rd_code_nxt  = '0;
                rd_valid_nxt = 1'b0;
            end
        end
    end

    always_ff @(posedge core_clk) begin
        if (ce) begin
            code_q     <= code_nxt;
            vld_q      <= vld_nxt;
            rd_code_r  <= rd_code_nxt;
            rd_valid_r <= rd_valid_nxt;
        end
    end

    assign hist.rd_code  = rd_code_r;
    assign hist.rd_valid = rd_valid_r;

    property p_clr_empty;
        @(posedge core_clk) ce && hist.clr && !hist.wr |=> vld_q == '0;
    endproperty
    a_clr_empty: assert property (p_clr_empty)
        else $error("history not empty after clear");

    property p_wr_newest;
        @(posedge core_clk) ce && hist.wr
            |=> vld_q[0] && code_q[0] == $past(hist.wr_code);
    endproperty
    a_wr_newest: assert property (p_wr_newest)
        else $error("new entry not at head");
endmodule : arm_hist_mem

// ==== design/arm_top.sv ====
// Contract
// - selected reset input pin, when asserted, clears resettable active alarms.
// - up and down keys pressed together act as an alarm reset.
// - history keeps the ten newest alarms, read by display command.
// - same code again within one hour is not recorded.
// - history survives alarm resets and power loss; only clear empties it.
// - history clear command empties the history.
// - the three clear commands are refused while parameter writes are inhibited.
// - option module presence and model checked; mismatch raises an alarm.
// - module alarm cleared only by its own clear command.
// - a module hardware error result is never cleared by command.
// - motor type differing from stored one raises alarm at startup.
// - motor change alarm cleared only by its own clear command.
// - encoder alarms stay active through alarm reset requests.
// - system alarms are never written into the history.
module arm_top
    import arm_pkg::*;
#(
    parameter int unsigned SEC_CYCLES_P = SEC_CYCLES
)(
    input  wire logic              core_clk,          // system clock
    input  wire logic              rst,               // sync reset, high
    input  wire logic              ce,                // clock enable
    input  wire logic [NPIN-1:0]   alarm_reset_input_n, // reset pins, low
    input  wire logic [PSEL_W-1:0] reset_input_pin_select, // pin choice
    input  wire logic              panel_up_key,      // up key held
    input  wire logic              panel_down_key,    // down key held
    input  wire logic              alarm_event,       // alarm occurs, pulse
    input  wire arm_code_t         alarm_code,        // code of that alarm
    input  wire logic              alarm_resettable,  // clears on reset
    input  wire logic              alarm_encoder,     // encoder class
    input  wire logic              alarm_system,      // panel-only class
    input  wire logic              param_write_inhibit, // writes locked
    input  wire logic              history_display_cmd, // read strobe
    input  wire arm_idx_t          history_index,     // 0 is newest
    input  wire logic              history_clear_cmd, // pulse
    input  wire logic              module_alarm_clear_cmd, // pulse
    input  wire logic              motor_change_alarm_clear_cmd, // pulse
    input  wire logic [CFG_W-1:0]  opt_detected_cfg,  // modules found
    input  wire logic [CFG_W-1:0]  opt_stored_cfg,    // modules expected
    input  wire logic              opt_hw_error,      // module hw fault
    input  wire arm_code_t         motor_type_id,     // motor identified
    input  wire arm_code_t         motor_type_stored, // previous motor
    output logic                   servo_alarm_output, // any alarm
    output arm_code_t              active_alarm_code, // current alarm
    output logic                   alarm_reset_pulse, // reset acted
    output arm_code_t              history_code,      // read data
    output logic                   history_valid,     // entry present
    output logic                   opt_cfg_alarm,     // module config
    output logic                   opt_hw_alarm,      // module hw fault
    output logic                   opt_cfg_save,      // store detected
    output logic                   motor_change_alarm, // motor changed
    output logic                   motor_type_save,   // store motor id
    output logic                   cmd_done,          // command accepted
    output logic                   cmd_refused        // command refused
);
    arm_hist_if hist ();

    arm_hist_mem arm_hist_mem_inst (
        .core_clk (core_clk),
        .ce       (ce),
        .hist     (hist.mem)
    );

    logic      req_r,       req_nxt;
    logic      pulse_r,     pulse_nxt;
    logic      act_valid_r, act_valid_nxt;
    arm_code_t act_code_r,  act_code_nxt;
    logic      act_res_r,   act_res_nxt;
    logic      act_enc_r,   act_enc_nxt;
    logic      alm_out_r,   alm_out_nxt;
    logic      start_r,     start_nxt;
    logic      opt_cfg_r,   opt_cfg_nxt;
    logic      opt_hw_r,    opt_hw_nxt;
    logic      opt_save_r,  opt_save_nxt;
    logic      mot_r,       mot_nxt;
    logic      mot_save_r,  mot_save_nxt;
    logic      done_r,      done_nxt;
    logic      refused_r,   refused_nxt;
    logic      last_vld_r,  last_vld_nxt;
    arm_code_t last_code_r, last_code_nxt;
    logic [31:0]       tick_r, tick_nxt;
    logic [HOUR_W-1:0] secs_r, secs_nxt;

    logic reset_req;
    logic reset_edge;
    logic any_cmd;
    logic dup_hit;
    logic rec;

    always_comb begin
        reset_req  = !alarm_reset_input_n[reset_input_pin_select]
                     || (panel_up_key && panel_down_key);
        reset_edge = reset_req && !req_r;
        any_cmd    = history_clear_cmd || module_alarm_clear_cmd
                     || motor_change_alarm_clear_cmd;
        dup_hit    = last_vld_r && alarm_code == last_code_r
                     && secs_r < HOUR_SEC;
        rec        = alarm_event && !alarm_system && !dup_hit;
    end

    always_comb begin
        req_nxt       = reset_req;
        pulse_nxt     = reset_edge;
        act_valid_nxt = act_valid_r;
        act_code_nxt  = act_code_r;
        act_res_nxt   = act_res_r;
        act_enc_nxt   = act_enc_r;
        if (alarm_event) begin
            // a new alarm wins over a reset in the same cycle
            act_valid_nxt = 1'b1;
            act_code_nxt  = alarm_code;
            act_res_nxt   = alarm_resettable;
            act_enc_nxt   = alarm_encoder;
        end else if (reset_edge && act_res_r && !act_enc_r) begin
            act_valid_nxt = 1'b0;
        end
    end

    always_comb begin
        start_nxt    = 1'b0;
        opt_cfg_nxt  = opt_cfg_r;
        opt_save_nxt = 1'b0;
        mot_nxt      = mot_r;
        mot_save_nxt = 1'b0;
        done_nxt     = 1'b0;
        refused_nxt  = 1'b0;
        opt_hw_nxt   = opt_hw_error;
        if (any_cmd && param_write_inhibit) begin
            refused_nxt = 1'b1;
        end else if (any_cmd) begin
            done_nxt = 1'b1;
            if (module_alarm_clear_cmd) begin
                opt_cfg_nxt  = 1'b0;
                opt_save_nxt = 1'b1;
            end
            if (motor_change_alarm_clear_cmd) begin
                mot_nxt      = 1'b0;
                mot_save_nxt = 1'b1;
            end
        end
        // compare modules and motor type at startup
        // a detected fault wins over a clear in the same cycle
        if (start_r && opt_detected_cfg != opt_stored_cfg) begin
            opt_cfg_nxt = 1'b1;
        end
        if (start_r && motor_type_id != motor_type_stored) begin
            mot_nxt = 1'b1;
        end
        alm_out_nxt = act_valid_nxt || opt_cfg_nxt || opt_hw_nxt || mot_nxt;
    end

    // duplicate window: seconds since the last non-system occurrence, recorded or not
    always_comb begin
        tick_nxt      = tick_r;
        secs_nxt      = secs_r;
        last_vld_nxt  = last_vld_r;
        last_code_nxt = last_code_r;
        if (tick_r >= SEC_CYCLES_P - 1) begin
            tick_nxt = '0;
            if (secs_r < HOUR_SEC) begin
                secs_nxt = secs_r + HOUR_W'(1);
            end
        end else begin
            tick_nxt = tick_r + 32'h1;
        end
        if (history_clear_cmd && !param_write_inhibit) begin
            last_vld_nxt = 1'b0;
        end
        if (alarm_event && !alarm_system) begin
            last_vld_nxt  = 1'b1;
            last_code_nxt = alarm_code;
            tick_nxt      = '0;
            secs_nxt      = '0;
        end
    end

    always_ff @(posedge core_clk) begin
        if (rst) begin
            req_r <= 1'b1; // a level held through reset is not an edge
            pulse_r <= 1'b0;
            act_valid_r <= 1'b0;
            act_code_r <= '0;
            act_res_r <= 1'b0;
            act_enc_r <= 1'b0;
            alm_out_r <= 1'b0;
            start_r <= 1'b1;
            opt_cfg_r <= 1'b0;
            opt_hw_r <= 1'b0;
            opt_save_r <= 1'b0;
            mot_r <= 1'b0;
            mot_save_r <= 1'b0;
            done_r <= 1'b0;
            refused_r <= 1'b0;
            last_vld_r <= 1'b0;
            last_code_r <= '0;
            tick_r <= '0;
            secs_r <= '0;
        end else if (ce) begin
            req_r <= req_nxt;
            pulse_r <= pulse_nxt;
            act_valid_r <= act_valid_nxt;
            act_code_r <= act_code_nxt;
            act_res_r <= act_res_nxt;
            act_enc_r <= act_enc_nxt;
            alm_out_r <= alm_out_nxt;
            start_r <= start_nxt;
            opt_cfg_r <= opt_cfg_nxt;
            opt_hw_r <= opt_hw_nxt;
            opt_save_r <= opt_save_nxt;
            mot_r <= mot_nxt;
            mot_save_r <= mot_save_nxt;
            done_r <= done_nxt;
            refused_r <= refused_nxt;
            last_vld_r <= last_vld_nxt;
            last_code_r <= last_code_nxt;
            tick_r <= tick_nxt;
            secs_r <= secs_nxt;
        end
    end

    // history only touched by writes and the clear command
    assign hist.wr      = ce && !rst && rec;
    assign hist.wr_code = alarm_code;
    assign hist.clr     = ce && !rst && history_clear_cmd
                          && !param_write_inhibit;
    assign hist.rd_en   = history_display_cmd;
    assign hist.rd_idx  = history_index;

    assign servo_alarm_output = alm_out_r;
    assign active_alarm_code  = act_code_r;
    assign alarm_reset_pulse  = pulse_r;
    assign history_code       = hist.rd_code;
    assign history_valid      = hist.rd_valid;
    assign opt_cfg_alarm      = opt_cfg_r;
    assign opt_hw_alarm       = opt_hw_r;
    assign opt_cfg_save       = opt_save_r;
    assign motor_change_alarm = mot_r;
    assign motor_type_save    = mot_save_r;
    assign cmd_done           = done_r;
    assign cmd_refused        = refused_r;

    default clocking cb @(posedge core_clk); endclocking
    default disable iff (rst);

    sequence s_cmd_ok;
        ce && !param_write_inhibit && !start_r;
    endsequence

    property p_rst_pulse;
        ce && reset_edge |=> alarm_reset_pulse;
    endproperty
    a_rst_pulse: assert property (p_rst_pulse)
        else $error("reset edge gave no pulse");

    property p_rst_once;
        ce && reset_req && req_r |=> !alarm_reset_pulse;
    endproperty
    a_rst_once: assert property (p_rst_once)
        else $error("held reset acted again");

    property p_keys;
        ce && !req_r && panel_up_key && panel_down_key |=> alarm_reset_pulse;
    endproperty
    a_keys: assert property (p_keys)
        else $error("key pair did not reset");

    property p_clear_res;
        ce && reset_edge && !alarm_event && act_valid_r && act_res_r
            && !act_enc_r |=> !act_valid_r;
    endproperty
    a_clear_res: assert property (p_clear_res)
        else $error("resettable alarm not cleared");

    property p_enc_keep;
        ce && !alarm_event && act_valid_r && act_enc_r |=> act_valid_r;
    endproperty
    a_enc_keep: assert property (p_enc_keep)
        else $error("encoder alarm cleared");

    property p_refuse;
        ce && param_write_inhibit && any_cmd |=> cmd_refused && !cmd_done;
    endproperty
    a_refuse: assert property (p_refuse)
        else $error("command not refused");

    property p_mot_clr;
        s_cmd_ok ##0 motor_change_alarm_clear_cmd
            |=> !motor_change_alarm ##0 motor_type_save;
    endproperty
    a_mot_clr: assert property (p_mot_clr)
        else $error("motor alarm not cleared");

    property p_mot_keep;
        ce && !start_r && motor_change_alarm
            && !(motor_change_alarm_clear_cmd && !param_write_inhibit)
            |=> motor_change_alarm;
    endproperty
    a_mot_keep: assert property (p_mot_keep)
        else $error("motor alarm dropped");

    property p_opt_keep;
        ce && !start_r && opt_cfg_alarm
            && !(module_alarm_clear_cmd && !param_write_inhibit)
            |=> opt_cfg_alarm;
    endproperty
    a_opt_keep: assert property (p_opt_keep)
        else $error("module alarm dropped");

    property p_sys_norec;
        ce && alarm_event && alarm_system |-> !hist.wr;
    endproperty
    a_sys_norec: assert property (p_sys_norec)
        else $error("system alarm recorded");

    property p_dup;
        ce && alarm_event && dup_hit |-> !hist.wr;
    endproperty
    a_dup: assert property (p_dup)
        else $error("duplicate recorded");
endmodule : arm_top

// ==== verification/arm_host_model.sv ====
module arm_host_model
    import arm_pkg::*;
(
    input  wire logic              core_clk,            // system clock
    input  wire logic              load,                // preset the store
    input  wire logic [CFG_W-1:0]  load_cfg,            // preset module cfg
    input  wire arm_code_t         load_motor,          // preset motor id
    input  wire logic              reset_req,           // hold reset input
    input  wire logic [PSEL_W-1:0] pin_sel,             // pin in use
    input  wire logic              opt_cfg_save,        // store cfg pulse
    input  wire logic              motor_type_save,     // store motor pulse
    input  wire logic [CFG_W-1:0]  opt_detected_cfg,    // found cfg
    input  wire arm_code_t         motor_type_id,       // found motor
    output logic [NPIN-1:0]        alarm_reset_input_n, // reset pins, low
    output logic [CFG_W-1:0]       opt_stored_cfg,      // stored cfg
    output arm_code_t              motor_type_stored    // stored motor
);
    timeunit 1ns;
    timeprecision 1ps;

    // selected pin
    // pins not in use sit at their pull-up level
    always_comb begin
        alarm_reset_input_n          = {NPIN{1'b1}};
        alarm_reset_input_n[pin_sel] = ~reset_req;
    end

    // outside store
    // the store moves on load and on the save pulses, so an accepted clear
    // writes the detected value at once, with no power cycle needed
    always_ff @(posedge core_clk) begin
        if (load) begin
            opt_stored_cfg    <= load_cfg;
            motor_type_stored <= load_motor;
        end else begin
            if (opt_cfg_save)
                opt_stored_cfg <= opt_detected_cfg;
            if (motor_type_save)
                motor_type_stored <= motor_type_id;
        end
    end
endmodule : arm_host_model

// ==== verification/arm_top_bench.sv ====
`define CHK(what, exp, got) begin n_checks++; if ((got) !== (exp)) begin \
    error_cnt++; \
    $display("unexpected %s: expected %0h, seen %0h", what, exp, got); end end

module arm_top_bench;
    timeunit 1ns;
    timeprecision 1ps;
    import arm_pkg::*;
    localparam int unsigned SEC_P = 4;

    logic core_clk, rst, ce, panel_up_key, panel_down_key, alarm_event;
    logic alarm_resettable, alarm_encoder, alarm_system;
    logic param_write_inhibit, history_display_cmd, history_clear_cmd;
    logic module_alarm_clear_cmd, motor_change_alarm_clear_cmd, opt_hw_error;
    logic load, reset_req, opt_cfg_save, motor_type_save;
    logic servo_alarm_output, alarm_reset_pulse, history_valid;
    logic opt_cfg_alarm, opt_hw_alarm, motor_change_alarm;
    logic cmd_done, cmd_refused;
    logic [NPIN-1:0]   alarm_reset_input_n;
    logic [PSEL_W-1:0] reset_input_pin_select;
    logic [CFG_W-1:0]  opt_detected_cfg, opt_stored_cfg;
    arm_code_t alarm_code, active_alarm_code, history_code;
    arm_code_t motor_type_id, motor_type_stored;
    arm_idx_t  history_index;
    int error_cnt = 0;
    int n_checks  = 0;

    arm_top #(.SEC_CYCLES_P(SEC_P)) arm_top_inst (
        .core_clk(core_clk), .rst(rst), .ce(ce),
        .alarm_reset_input_n(alarm_reset_input_n),
        .reset_input_pin_select(reset_input_pin_select),
        .panel_up_key(panel_up_key), .panel_down_key(panel_down_key),
        .alarm_event(alarm_event), .alarm_code(alarm_code),
        .alarm_resettable(alarm_resettable), .alarm_encoder(alarm_encoder),
        .alarm_system(alarm_system),
        .param_write_inhibit(param_write_inhibit),
        .history_display_cmd(history_display_cmd),
        .history_index(history_index), .history_clear_cmd(history_clear_cmd),
        .module_alarm_clear_cmd(module_alarm_clear_cmd),
        .motor_change_alarm_clear_cmd(motor_change_alarm_clear_cmd),
        .opt_detected_cfg(opt_detected_cfg), .opt_stored_cfg(opt_stored_cfg),
        .opt_hw_error(opt_hw_error), .motor_type_id(motor_type_id),
        .motor_type_stored(motor_type_stored),
        .servo_alarm_output(servo_alarm_output),
        .active_alarm_code(active_alarm_code),
        .alarm_reset_pulse(alarm_reset_pulse), .history_code(history_code),
        .history_valid(history_valid), .opt_cfg_alarm(opt_cfg_alarm),
        .opt_hw_alarm(opt_hw_alarm), .opt_cfg_save(opt_cfg_save),
        .motor_change_alarm(motor_change_alarm),
        .motor_type_save(motor_type_save),
        .cmd_done(cmd_done), .cmd_refused(cmd_refused));

    arm_host_model arm_host_model_inst (
        .core_clk(core_clk), .load(load), .load_cfg(8'h01),
        .load_motor(8'h21), .reset_req(reset_req),
        .pin_sel(reset_input_pin_select), .opt_cfg_save(opt_cfg_save),
        .motor_type_save(motor_type_save),
        .opt_detected_cfg(opt_detected_cfg), .motor_type_id(motor_type_id),
        .alarm_reset_input_n(alarm_reset_input_n),
        .opt_stored_cfg(opt_stored_cfg),
        .motor_type_stored(motor_type_stored));

    initial begin
        core_clk = 1'b0;
        forever #10 core_clk = ~core_clk;
    end

    task automatic end_sim();
        if (error_cnt == 0 && n_checks > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask : end_sim

    task automatic alarm(input arm_code_t c, input logic res, enc, sys);
        @(posedge core_clk);
        alarm_event      <= 1'b1;
        alarm_code       <= c;
        alarm_resettable <= res;
        alarm_encoder    <= enc;
        alarm_system     <= sys;
        @(posedge core_clk);
        alarm_event <= 1'b0;
        #1;
        `CHK("active code", c, active_alarm_code)
        `CHK("alarm out", 1'b1, servo_alarm_output)
    endtask : alarm

    task automatic cmd(input int k, input logic inh);
        @(posedge core_clk);
        param_write_inhibit           <= inh;
        history_clear_cmd             <= (k == 0);
        module_alarm_clear_cmd        <= (k == 1);
        motor_change_alarm_clear_cmd  <= (k == 2);
        @(posedge core_clk);
        history_clear_cmd             <= 1'b0;
        module_alarm_clear_cmd        <= 1'b0;
        motor_change_alarm_clear_cmd  <= 1'b0;
        #1;
        `CHK("cmd_done", !inh, cmd_done)
        `CHK("cmd_refused", inh, cmd_refused)
    endtask : cmd

    task automatic rd(input int i, input logic v, input arm_code_t c);
        @(posedge core_clk);
        history_display_cmd <= 1'b1;
        history_index       <= arm_idx_t'(i);
        @(posedge core_clk);
        history_display_cmd <= 1'b0;
        #1;
        `CHK("history_valid", v, history_valid)
        if (v) `CHK("history_code", c, history_code)
    endtask : rd

    // one request, held for several cycles, must act exactly once
    task automatic rreq(input logic keys, input logic exp_alm);
        @(posedge core_clk);
        reset_req      <= !keys;
        panel_up_key   <= keys;
        panel_down_key <= keys;
        @(posedge core_clk);
        #1;
        `CHK("reset pulse", 1'b1, alarm_reset_pulse)
        `CHK("alarm after reset", exp_alm, servo_alarm_output)
        repeat (3) @(posedge core_clk);
        #1;
        `CHK("reset pulse held", 1'b0, alarm_reset_pulse)
        @(posedge core_clk);
        reset_req      <= 1'b0;
        panel_up_key   <= 1'b0;
        panel_down_key <= 1'b0;
        repeat (2) @(posedge core_clk);
    endtask : rreq

    task automatic power_cycle();
        @(posedge core_clk);
        rst <= 1'b1;
        @(posedge core_clk);
        rst <= 1'b0;
        repeat (3) @(posedge core_clk);
        #1;
    endtask : power_cycle

    task automatic t_hist_clear();
        cmd(0, 1'b0);
        alarm(8'h11, 1'b1, 1'b0, 1'b0);
        cmd(0, 1'b1);
        rd(0, 1'b1, 8'h11);
        cmd(0, 1'b0);
        rd(0, 1'b0, 8'h00);
    endtask : t_hist_clear

    task automatic t_fill();
        for (int i = 1; i <= 11; i++)
            alarm(arm_code_t'(i), 1'b1, 1'b0, 1'b0);
        alarm(8'hF0, 1'b1, 1'b0, 1'b1);
        rd(0, 1'b1, 8'h0B);
        rd(9, 1'b1, 8'h02);
        rd(10, 1'b0, 8'h00);
    endtask : t_fill

    task automatic t_dup();
        alarm(8'h22, 1'b1, 1'b0, 1'b0);
        alarm(8'h22, 1'b1, 1'b0, 1'b0);
        rd(1, 1'b1, 8'h0B);
        // the seconds tick is coarse, so wait a few ticks past the hour
        repeat (SEC_P * 3600 + 4 * SEC_P) @(posedge core_clk);
        alarm(8'h22, 1'b1, 1'b0, 1'b0);
        rd(1, 1'b1, 8'h22);
    endtask : t_dup

    task automatic t_reset();
        alarm(8'h33, 1'b1, 1'b0, 1'b0);
        rreq(1'b0, 1'b0);
        alarm(8'h44, 1'b1, 1'b0, 1'b0);
        rreq(1'b1, 1'b0);
        alarm(8'h55, 1'b1, 1'b1, 1'b0);
        rreq(1'b0, 1'b1);
        rd(0, 1'b1, 8'h55);
        power_cycle();
        rd(1, 1'b1, 8'h44);
    endtask : t_reset

    task automatic t_startup();
        @(posedge core_clk);
        opt_detected_cfg <= 8'h03;
        motor_type_id    <= 8'h22;
        power_cycle();
        `CHK("module alarm", 1'b1, opt_cfg_alarm)
        `CHK("motor alarm", 1'b1, motor_change_alarm)
        rreq(1'b0, 1'b1);
        power_cycle();
        `CHK("module alarm kept", 1'b1, opt_cfg_alarm)
        `CHK("motor alarm kept", 1'b1, motor_change_alarm)
        cmd(2, 1'b1);
        `CHK("motor alarm refused", 1'b1, motor_change_alarm)
        cmd(2, 1'b0);
        `CHK("motor alarm cleared", 1'b0, motor_change_alarm)
        cmd(1, 1'b0);
        `CHK("module alarm cleared", 1'b0, opt_cfg_alarm)
        @(posedge core_clk);
        opt_hw_error <= 1'b1;
        repeat (3) @(posedge core_clk);
        cmd(1, 1'b0);
        `CHK("module hw alarm", 1'b1, opt_hw_alarm)
        @(posedge core_clk);
        opt_hw_error <= 1'b0;
        power_cycle();
        `CHK("module alarm after cycle", 1'b0, opt_cfg_alarm)
        `CHK("motor alarm after cycle", 1'b0, motor_change_alarm)
        `CHK("alarm out idle", 1'b0, servo_alarm_output)
    endtask : t_startup

    initial begin
        repeat (40000) @(posedge core_clk);
        error_cnt++;
        end_sim();
    end

    initial begin
        rst = 1'b1;
        ce = 1'b1;
        load = 1'b1;
        reset_req = 1'b0;
        reset_input_pin_select = 3'h5;
        panel_up_key = 1'b0;
        panel_down_key = 1'b0;
        alarm_event = 1'b0;
        alarm_code = 8'h00;
        alarm_resettable = 1'b0;
        alarm_encoder = 1'b0;
        alarm_system = 1'b0;
        param_write_inhibit = 1'b0;
        history_display_cmd = 1'b0;
        history_index = 4'h0;
        history_clear_cmd = 1'b0;
        module_alarm_clear_cmd = 1'b0;
        motor_change_alarm_clear_cmd = 1'b0;
        opt_detected_cfg = 8'h01;
        opt_hw_error = 1'b0;
        motor_type_id = 8'h21;
        repeat (20) @(posedge core_clk);
        rst <= 1'b0;
        load <= 1'b0;
        t_hist_clear();
        t_fill();
        t_dup();
        t_reset();
        t_startup();
        end_sim();
    end
endmodule : arm_top_bench
